// >>> hdl/current_channel_filter_output_config.sv
`timescale 1ns/1ps
`include "chan_filter_defs.svh"

module current_channel_filter_output_config (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   wr_en_i,
	input  wire logic [7:0]             wr_addr_i,
	input  wire logic [7:0]             wr_data_i,
	input  wire logic [7:0]             rd_addr_i,
	output logic      [7:0]             rd_data_o,
	input  wire logic                   standby_measurement_mode_i,
	input  wire logic [15:0]            fir_data_i,
	input  wire logic                   fir_valid_i,
	input  wire logic [15:0]            cic2_data_i,
	input  wire logic                   cic2_valid_i,
	input  wire logic [15:0]            demod_data_i,
	input  wire logic                   demod_valid_i,
	input  wire logic [15:0]            cic1_data_i,
	input  wire logic                   cic1_valid_i,
	output logic      [15:0]            result_o,
	output logic                        result_valid_o,
	output logic                        int_o,
	output logic                        i_chan_en_o,
	output logic                        v_chan_en_o,
	output chan_filter_pkg::path_t      path_sel_o
);
	import chan_filter_pkg::*;

	localparam int HD = `MA_HIST_DEPTH;

	logic [7:0]          chan_cfg;
	logic [7:0]          filt_ctl;
	logic [7:0]          next_chan_cfg;
	logic [7:0]          next_filt_ctl;
	logic [7:0]          next_rd_data;
	logic [15:0]         hist [HD];
	logic [15:0]         next_hist [HD];
	logic                ma_valid;
	logic                next_ma_valid;
	logic [19:0]         masked [HD];
	logic [19:0]         ma_sum;
	logic [2:0]          ma_shift;
	logic [15:0]         ma_avg;
	logic [15:0]         final_data;
	logic                final_valid;
	src_t                src_sel;
	logic [15:0]         sel_data;
	logic                sel_valid;
	logic [15:0]         next_result;
	logic                next_result_valid;
	logic                next_int;
	logic                next_i_en;
	logic                next_v_en;
	path_t               next_path;

	// register writes and read mux
	always_comb begin
		next_chan_cfg = chan_cfg;
		next_filt_ctl = filt_ctl;
		// unmapped write addresses leave both registers alone
		if (wr_en_i && wr_addr_i == `CHAN_CFG_ADDR) begin
			next_chan_cfg = wr_data_i;
		end
		if (wr_en_i && wr_addr_i == `FILT_CTL_ADDR) begin
			next_filt_ctl = wr_data_i;
		end
		next_filt_ctl[`FC_RSVD_BIT] = 1'b0;
		case (rd_addr_i)
			`CHAN_CFG_ADDR: next_rd_data = chan_cfg;
			`FILT_CTL_ADDR: next_rd_data = filt_ctl;
			default:        next_rd_data = 8'h00;
		endcase
	end

	// register state, reset values
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chan_cfg  <= `CHAN_CFG_RESET;
			filt_ctl  <= `FILT_CTL_RESET;
			rd_data_o <= 8'h00;
		end else begin
			chan_cfg  <= next_chan_cfg;
			filt_ctl  <= next_filt_ctl;
			rd_data_o <= next_rd_data;
		end
	end

	// averaging history shifts on each comb-stage sample
	always_comb begin
		for (int i = 0; i < HD; i++) begin
			next_hist[i] = hist[i];
		end
		if (cic2_valid_i) begin
			next_hist[0] = cic2_data_i;
			for (int i = 1; i < HD; i++) begin
				next_hist[i] = hist[i-1];
			end
		end
		next_ma_valid = cic2_valid_i;
	end

	// history registers, zero after reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < HD; i++) begin
				hist[i] <= 16'h0000;
			end
			ma_valid <= 1'b0;
		end else begin
			for (int i = 0; i < HD; i++) begin
				hist[i] <= next_hist[i];
			end
			ma_valid <= next_ma_valid;
		end
	end

	// history survives depth changes, so a new window mixes older samples
	// depth sets window of 2**k samples, k being the number of set bits in the depth field
	assign ma_shift = 3'(filt_ctl[`FC_DEPTH_LO]) + 3'(filt_ctl[`FC_DEPTH_LO+1])
	                + 3'(filt_ctl[`FC_DEPTH_LO+2]) + 3'(filt_ctl[`FC_DEPTH_HI]);

	// per-entry window masking, sign extended
	for (genvar g = 0; g < HD; g++) begin : g_win
		assign masked[g] = (g < (1 << ma_shift)) ? {{4{hist[g][15]}}, hist[g]} : 20'h00000;
	end

	// window sum and scaled average
	always_comb begin
		ma_sum = 20'h00000;
		for (int i = 0; i < HD; i++) begin
			ma_sum = ma_sum + masked[i];
		end
		ma_avg = 16'($signed(ma_sum) >>> ma_shift);
	end

	always_comb begin
		if (filt_ctl[`FC_MA_SEL_BIT]) begin
			final_data  = ma_avg;
			final_valid = ma_valid;
		end else begin
			final_data  = fir_data_i;
			final_valid = fir_valid_i;
		end
	end

	always_comb begin
		if (standby_measurement_mode_i) begin
			src_sel = src_t'(chan_cfg[`CFG_STBY_SRC_HI:`CFG_STBY_SRC_LO]);
		end else begin
			src_sel = src_t'(chan_cfg[`CFG_NORM_SRC_HI:`CFG_NORM_SRC_LO]);
		end
		case (src_sel)
			SRC_FINAL: begin
				sel_data  = final_data;
				sel_valid = final_valid;
			end
			SRC_CIC2: begin
				sel_data  = cic2_data_i;
				sel_valid = cic2_valid_i;
			end
			SRC_DEMOD: begin
				sel_data  = demod_data_i;
				sel_valid = demod_valid_i;
			end
			default: begin
				sel_data  = cic1_data_i;
				sel_valid = cic1_valid_i;
			end
		endcase
	end

	// result capture, ready pulse and pin
	always_comb begin
		next_i_en         = chan_cfg[`CFG_I_EN_BIT];
		next_v_en         = chan_cfg[`CFG_V_EN_BIT];
		next_result_valid = sel_valid & chan_cfg[`CFG_I_EN_BIT];
		next_result       = next_result_valid ? sel_data : result_o;
		next_int          = (next_result_valid & ~chan_cfg[`CFG_MASK_BIT]) ^ chan_cfg[`CFG_POL_BIT];
		next_path         = path_t'(filt_ctl[`FC_PATH_HI:`FC_PATH_LO]);
	end

	// output registers, idle levels at reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_o       <= 16'h0000;
			result_valid_o <= 1'b0;
			int_o          <= 1'b0;
			i_chan_en_o    <= 1'b1;
			v_chan_en_o    <= 1'b1;
			path_sel_o     <= PATH_DECHOP_AFTER;
		end else begin
			result_o       <= next_result;
			result_valid_o <= next_result_valid;
			int_o          <= next_int;
			i_chan_en_o    <= next_i_en;
			v_chan_en_o    <= next_v_en;
			path_sel_o     <= next_path;
		end
	end

endmodule // current_channel_filter_output_config

// >>> hdl/chan_filter_defs.svh
`ifndef CHAN_FILTER_DEFS_SVH
`define CHAN_FILTER_DEFS_SVH

// register offsets
`define CHAN_CFG_ADDR        8'h06
`define FILT_CTL_ADDR        8'h07

// reset values
`define CHAN_CFG_RESET       8'hC5
`define FILT_CTL_RESET       8'h04

// channel_output_config fields
`define CFG_I_EN_BIT         7
`define CFG_V_EN_BIT         6
`define CFG_POL_BIT          5
`define CFG_MASK_BIT         4
`define CFG_NORM_SRC_HI      3
`define CFG_NORM_SRC_LO      2
`define CFG_STBY_SRC_HI      1
`define CFG_STBY_SRC_LO      0

// final_filter_control fields
`define FC_MA_SEL_BIT        7
`define FC_DEPTH_HI          6
`define FC_DEPTH_LO          3
`define FC_PATH_HI           2
`define FC_PATH_LO           1
`define FC_RSVD_BIT          0

// averaging history depth
`define MA_HIST_DEPTH        16

`endif

// >>> hdl/chan_filter_pkg.sv
package chan_filter_pkg;

	// result source selection
	typedef enum logic [1:0] {
		SRC_FINAL = 2'h0,
		SRC_CIC2  = 2'h1,
		SRC_DEMOD = 2'h2,
		SRC_CIC1  = 2'h3
	} src_t;

	// measurement path architecture
	typedef enum logic [1:0] {
		PATH_DEMOD_AFTER   = 2'h0,
		PATH_DEMOD_BEFORE  = 2'h1,
		PATH_DECHOP_AFTER  = 2'h2,
		PATH_DEMOD_SETTLED = 2'h3
	} path_t;

endpackage

// >>> tb/cc_filter_properties.sv
`timescale 1ns/1ps
module cc_filter_checker
	import chan_filter_pkg::*;
(
	input wire logic       clk_i, resetn_i, wr_en_i, result_valid_o, int_o,
	input wire logic       fir_valid_i, cic2_valid_i, demod_valid_i, cic1_valid_i,
	input wire logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o,
	input wire logic       i_chan_en_o, v_chan_en_o,
	input wire path_t      path_sel_o
);
	logic [1:0] pm;
	wire any_vld = fir_valid_i | cic2_valid_i | demod_valid_i | cic1_valid_i;
	// shadow of polarity and mask bits
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) pm <= 2'h0;
		else if (wr_en_i && wr_addr_i == 8'h06) pm <= wr_data_i[5:4];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_rd_unmapped: assert property (!(rd_addr_i inside {8'h06, 8'h07}) |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	a_rd_cfg: assert property (rd_addr_i == 8'h06 |=> rd_data_o[7:4] == {i_chan_en_o, v_chan_en_o, $past(pm)})
		else $error("config readback wrong");
	a_rd_ctl: assert property (rd_addr_i == 8'h07 |=> rd_data_o[2:0] == {path_sel_o, 1'b0})
		else $error("control readback wrong");
	a_en_follow: assert property (wr_en_i && wr_addr_i == 8'h06 |=> ##1 {i_chan_en_o, v_chan_en_o} == $past(wr_data_i[7:6], 2))
		else $error("enables do not follow write");
	a_path_follow: assert property (wr_en_i && wr_addr_i == 8'h07 |-> ##2 path_sel_o == $past(wr_data_i[2:1], 2))
		else $error("path does not follow write");
	a_int_level: assert property (int_o == ((result_valid_o & ~$past(pm[0])) ^ $past(pm[1])))
		else $error("interrupt level wrong");
	a_disabled_drop: assert property (!i_chan_en_o [*3] |-> !result_valid_o)
		else $error("result while disabled");
	a_quiet_idle: assert property (!any_vld [*2] |=> !result_valid_o)
		else $error("result without sample");
	c_int: cover property (result_valid_o && int_o);
	c_off: cover property (!i_chan_en_o);
	c_ctl: cover property (wr_en_i && wr_addr_i == 8'h07);
endmodule // cc_filter_checker

bind current_channel_filter_output_config cc_filter_checker chk (
	.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .result_valid_o(result_valid_o), .int_o(int_o),
	.fir_valid_i(fir_valid_i), .cic2_valid_i(cic2_valid_i), .demod_valid_i(demod_valid_i),
	.cic1_valid_i(cic1_valid_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
	.rd_data_o(rd_data_o), .i_chan_en_o(i_chan_en_o), .v_chan_en_o(v_chan_en_o), .path_sel_o(path_sel_o)
);

// >>> tb/filt_src_model.sv
`timescale 1ns/1ps
module filt_src_model (
	input  wire logic        clk_i,
	input  wire logic [3:0]  go_i,
	input  wire logic [15:0] dat_i,
	output logic      [3:0]  vld_o = 4'h0,
	output logic      [15:0] dat_o = 16'h0
);
	// one-cycle valid per request, data toggles while idle
	always @(posedge clk_i) begin
		vld_o <= go_i;
		dat_o <= |go_i ? dat_i : ~dat_o;
	end
endmodule // filt_src_model

// >>> tb/current_channel_filter_output_config_test.sv
`timescale 1ns/1ps
module current_channel_filter_output_config_test;
	import chan_filter_pkg::*;
	logic clk_i = 0, resetn_i = 0, wr_en_i = 0, standby_measurement_mode_i = 0, pl = 0, mk = 0;
	logic [7:0] wr_addr_i = 0, wr_data_i = 0, rd_addr_i = 0, rd_data_o, dv[3] = '{8'h9C, 8'hBC, 8'hFC};
	logic [3:0] go = 0, vld;
	logic [15:0] din = 0, dat, result_o;
	logic [1:0] n, t;
	wire logic [15:0] fir_data_i = dat, cic2_data_i = dat, demod_data_i = dat, cic1_data_i = dat;
	wire logic fir_valid_i = vld[0], cic2_valid_i = vld[1], demod_valid_i = vld[2], cic1_valid_i = vld[3];
	logic result_valid_o, int_o, i_chan_en_o, v_chan_en_o;
	path_t path_sel_o;
	int err_count = 0, checks = 0;
	// zero samples that leave one of the old negative samples in the window, and the averages they give
	int nz[3] = '{3, 7, 15};
	logic [15:0] ev[3] = '{16'hFF00, 16'hFF80, 16'hFFC0};
	current_channel_filter_output_config DUT (
		.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
		.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .standby_measurement_mode_i(standby_measurement_mode_i),
		.fir_data_i(fir_data_i), .fir_valid_i(fir_valid_i), .cic2_data_i(cic2_data_i), .cic2_valid_i(cic2_valid_i),
		.demod_data_i(demod_data_i), .demod_valid_i(demod_valid_i), .cic1_data_i(cic1_data_i),
		.cic1_valid_i(cic1_valid_i), .result_o(result_o), .result_valid_o(result_valid_o), .int_o(int_o),
		.i_chan_en_o(i_chan_en_o), .v_chan_en_o(v_chan_en_o), .path_sel_o(path_sel_o)
	);
	filt_src_model src (.clk_i(clk_i), .go_i(go), .dat_i(din), .vld_o(vld), .dat_o(dat));
	initial forever #12.5 clk_i = ~clk_i;
	task chk(input logic [15:0] v, e);
		checks++;
		if (v !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, v, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk_i) begin
			wr_en_i <= 1;
			wr_addr_i <= a;
			wr_data_i <= d;
		end
		@(posedge clk_i) wr_en_i <= 0;
		if (a == 8'h06) {pl, mk} = d[5:4];
	endtask
	task rdc(input logic [7:0] a, e);
		@(posedge clk_i) rd_addr_i <= a;
		@(posedge clk_i) #1 chk(rd_data_o, e);
	endtask
	// one sample on source s, x extra cycles of latency
	task smp(input int s, input logic [15:0] d, input int x);
		@(posedge clk_i) begin
			go <= 4'(1 << s);
			din <= d;
		end
		@(posedge clk_i) go <= 0;
		repeat (1 + x) @(posedge clk_i);
		#1;
	endtask
	task rchk(input logic [15:0] e, input logic v);
		chk(result_valid_o, v);
		if (v) chk(result_o, e);
		chk(int_o, (v & ~mk) ^ pl);
	endtask
	initial begin
		#200000 err_count++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1;
		rdc(8'h06, 8'hC5);
		rdc(8'h07, 8'h04);
		rdc(8'h3A, 8'h00);
		chk({i_chan_en_o, v_chan_en_o, path_sel_o}, 4'hE);
		wr(8'h07, 8'hFF);
		rdc(8'h07, 8'hFE);
		for (int p = 0; p < 4; p++) begin
			wr(8'h07, 8'(p << 1));
			@(posedge clk_i) #1 chk(path_sel_o, 16'(p));
		end
		wr(8'h07, 8'h04);
		$display("register test done");
		for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++) begin
			n = 2'(s + m);
			t = 2'(s + 1 - m);
			wr(8'h06, {4'hC, n, t});
			standby_measurement_mode_i <= m[0];
			smp((s + 1) % 4, 16'h0BAD, 0);
			rchk(0, 0);
			smp(s, 16'h1234 + 16'(s), 0);
			rchk(16'h1234 + 16'(s), 1);
		end
		@(posedge clk_i) standby_measurement_mode_i <= 0;
		for (int k = 0; k < 4; k++) begin
			wr(8'h06, 8'hC4 | 8'(k << 4));
			smp(1, 16'h00A5, 0);
			rchk(16'h00A5, 1);
			@(posedge clk_i) #1 chk(int_o, pl);
		end
		wr(8'h06, 8'h05);
		smp(1, 16'h0777, 0);
		rchk(0, 0);
		chk({i_chan_en_o, v_chan_en_o}, 2'h0);
		wr(8'h06, 8'h80);
		$display("source test done");
		wr(8'h07, 8'h84);
		smp(1, 16'h0123, 1);
		rchk(16'h0123, 1);
		chk({i_chan_en_o, v_chan_en_o}, 2'h2);
		smp(0, 16'h0999, 0);
		rchk(0, 0);
		wr(8'h07, 8'h8C);
		smp(1, 16'h0010, 1);
		smp(1, 16'h0030, 1);
		rchk(16'h0020, 1);
		foreach (dv[i]) begin
			wr(8'h07, dv[i]);
			repeat (16) smp(1, 16'hFC00, 1);
			repeat (nz[i]) smp(1, 16'h0000, 1);
			rchk(ev[i], 1);
		end
		wr(8'h07, 8'h04);
		smp(0, 16'h4321, 0);
		rchk(16'h4321, 1);
		$display("filter test done");
		report_and_stop;
	end
endmodule // current_channel_filter_output_config_test
